// *** hw/pil_map.vh ***
`ifndef PIL_MAP_VH
`define PIL_MAP_VH
// Register offsets (word index on the plain port)
`define PIL_ADDR_W        4
`define PIL_REG_CTRL      4'h0
`define PIL_REG_STATUS    4'h1
`define PIL_REG_IRQ_STAT  4'h2
`define PIL_REG_IRQ_MASK  4'h3
`define PIL_REG_STRAP     4'h4
// Control register fields
`define PIL_CTRL_ISOLATE  10
`define PIL_CTRL_FDX      8
`define PIL_CTRL_RST_VAL  16'h0000
// Interrupt event bits
`define PIL_EV_LINK_UP    0
`define PIL_EV_LINK_DN    1
`define PIL_EV_ISO_CHG    2
`define PIL_EV_W          3
// Timing
`define PIL_CLK_MHZ       250
`define PIL_QUAL_MS       500
`define PIL_NLP_MS        16
`define PIL_ACT_HOLD      16'h1000
`endif

// *** hw/pil_isolate_leds.v ***
// Functional notes
// - Writing one to control bit 10 isolates the MAC data path.
// - Clearing control bit 10 restores normal data path operation.
// - While isolated, transmit data, enable and error from MAC are ignored.
// - While isolated, MAC-facing clocks, receive data, collision, carrier are floated.
// - While isolated, management register reads and writes still work.
// - While isolated, all media-side transmit activity stops.
// - Five indicators: 10M link, 100M link, 1G link, activity, duplex.
// - 10M link lights on link pulses 16 ms apart or received packets.
// - 100M link follows qualified internal signal detect.
// - 1G link lights after autonegotiation done and reliable reception.
// - Link asserts only after signal detect holds 500 ms continuously.
// - Link drops immediately when signal detect falls.
// - Activity lights on receive, transmit or idle error.
// - Duplex indicator lit while running full duplex.
// - Indicator polarity from strap at reset: low strap active high.
//
// The plain strobed port and the address map were left to the implementer.

`include "pil_map.vh"
`timescale 1ns/1ps
`default_nettype none
module pil_isolate_leds #(
    parameter QUAL_CYC = `PIL_QUAL_MS * `PIL_CLK_MHZ * 1000,     // Signal detect qualification
    parameter NLP_CYC  = `PIL_NLP_MS * `PIL_CLK_MHZ * 1000 * 2,  // Link pulse gap timeout
    parameter CNT_W    = 30                                       // Timer width
) (
    input  wire        mclk,           // 250 MHz clock
    input  wire        rst_n,          // Synchronous reset, active low
    input  wire [3:0]  addr,           // Register index
    input  wire [15:0] wdata,          // Write data
    input  wire        wr,             // Write strobe
    input  wire        rd,             // Read strobe
    output reg  [15:0] rdata,          // Read data, cycle after rd
    output wire        irq,            // Level interrupt
    input  wire        tx_clk_in,      // Internal transmit clock
    input  wire        rx_clk_in,      // Internal receive clock (link clock)
    input  wire [3:0]  mac_txd,        // From MAC
    input  wire        mac_tx_en,      // From MAC
    input  wire        mac_tx_er,      // From MAC
    output reg  [3:0]  core_txd,       // To media side
    output reg         core_tx_en,     // To media side
    output reg         core_tx_er,     // To media side
    input  wire [3:0]  core_rxd,       // Receive data from core
    input  wire        core_rx_dv,     // Receive valid from core
    input  wire        core_rx_er,     // Receive error from core
    input  wire        core_col,       // Collision from core
    input  wire        core_crs,       // Carrier from core
    output wire [10:0] mac_out,        // tx_clk,rx_clk,rx_dv,rx_er,rxd[3:0],col,crs,pad
    output wire [10:0] mac_out_oe_n,   // Enables, low while driven
    output reg         media_en,       // Media side active
    input  wire        sig_det,        // Internal signal detect (async)
    input  wire        nlp,            // Normal link pulse seen (async level)
    input  wire        an_done,        // Autoneg complete (async)
    input  wire        rx_ok,          // Reliable reception (async)
    input  wire        idle_err,       // Idle error (async)
    input  wire [1:0]  speed,          // 0=10M 1=100M 2=1G (async)
    input  wire [4:0]  strap_in,       // Indicator strap levels
    output wire [4:0]  led_oe_n,       // Indicator pin enables, low drives
    output reg  [4:0]  led_out         // link_10m,link_100m,link_1g,traffic,full_duplex
);
    // Media side run states
    localparam ST_IDLE = 1'b0;
    localparam ST_RUN  = 1'b1;
    // Last counts, cut to the timer width on purpose
    localparam [CNT_W-1:0] QUAL_LAST = QUAL_CYC - 1;
    localparam [CNT_W-1:0] NLP_LAST  = NLP_CYC - 1;
    // Speed codes on the speed input
    localparam [1:0] SPD_10M  = 2'h0;
    localparam [1:0] SPD_100M = 2'h1;
    localparam [1:0] SPD_1G   = 2'h2;
    localparam       NUM_LED  = 5;

    // Control, interrupt and strap registers
    reg [15:0] basic_mode_control_reg;
    reg [`PIL_EV_W-1:0] irq_stat_r;
    reg [`PIL_EV_W-1:0] irq_mask_r;
    reg [4:0]  strap_r;
    reg        strap_done_r;
    // Synchroniser stages
    reg [6:0]  s1_r;
    reg [6:0]  s2_r;
    reg [2:0]  rxc_r;
    reg [2:0]  a1_r;
    reg [2:0]  a2_r;
    // Timers, qualified link and run state
    reg [CNT_W-1:0] qual_cnt_r;
    reg        link_r;
    reg [CNT_W-1:0] nlp_cnt_r;
    reg        nlp_q_r;
    reg        link10_r;
    reg [15:0] act_cnt_r;
    reg        state_r;
    reg        iso_q_r;
    // Control bits and synchronised levels
    wire       isolate = basic_mode_control_reg[`PIL_CTRL_ISOLATE];
    wire       fdx = basic_mode_control_reg[`PIL_CTRL_FDX];
    wire       sd_s = s2_r[0];
    wire       nlp_s = s2_r[1];
    wire       an_s = s2_r[2];
    wire       rxok_s = s2_r[3];
    wire       ierr_s = s2_r[4];
    wire [1:0] spd_s = s2_r[6:5];
    wire       rxc_rise = rxc_r[1] & ~rxc_r[2];
    wire       rxdv_s = a2_r[0];
    wire       rx_act = a2_r[0] | a2_r[1];
    wire       tx_act = ~isolate & a2_r[2];
    wire [`PIL_EV_W-1:0] ev;
    wire [4:0] led_lvl;

    // Two-flop synchronisers for async status levels and the receive clock
    // Only the second stage is read; the third receive clock stage finds edges
    // Reset values are the idle levels, so no false edge follows reset
    always @(posedge mclk) begin
        if (!rst_n) begin
            s1_r  <= 7'h00;
            s2_r  <= 7'h00;
            rxc_r <= 3'h0;
        end else begin
            s1_r  <= {speed, idle_err, rx_ok, an_done, nlp, sig_det};
            s2_r  <= s1_r;
            rxc_r <= {rxc_r[1:0], rx_clk_in};
        end
    end

    // Core receive flags and MAC transmit enable come from other clocks
    // They only feed the activity stretch and the packet test
    always @(posedge mclk) begin
        if (!rst_n) begin
            a1_r <= 3'h0;
            a2_r <= 3'h0;
        end else begin
            a1_r <= {mac_tx_en, core_crs, core_rx_dv};
            a2_r <= a1_r;
        end
    end

    // Strap capture one cycle after reset release
    // Indicator pins double as straps, so drivers stay off until latched
    always @(posedge mclk) begin
        if (!rst_n) begin
            strap_r      <= 5'h00;
            strap_done_r <= 1'b0;
        end else if (!strap_done_r) begin
            strap_r      <= strap_in;
            strap_done_r <= 1'b1;
        end
    end

    // Register writes and sticky event flags; set beats clear
    // Isolate only gates the MAC data path; this port stays live throughout
    always @(posedge mclk) begin
        if (!rst_n) begin
            basic_mode_control_reg <= `PIL_CTRL_RST_VAL;
            irq_mask_r <= 3'h0;
            irq_stat_r <= 3'h0;
        end else begin
            if (wr && addr == `PIL_REG_CTRL)
                basic_mode_control_reg <= wdata;
            if (wr && addr == `PIL_REG_IRQ_MASK)
                irq_mask_r <= wdata[`PIL_EV_W-1:0];
            // Write-one clear; an event in the same cycle keeps its flag
            if (wr && addr == `PIL_REG_IRQ_STAT)
                irq_stat_r <= (irq_stat_r & ~wdata[`PIL_EV_W-1:0]) | ev;
            else
                irq_stat_r <= irq_stat_r | ev;
        end
    end

    // Read port, answers also while isolated
    // Read data fall back to zero outside the answer cycle
    always @(posedge mclk) begin
        if (!rst_n) begin
            rdata <= 16'h0000;
        end else if (rd) begin
            case (addr)
                `PIL_REG_CTRL:     rdata <= basic_mode_control_reg;
                `PIL_REG_STATUS:   rdata <= {8'h00, state_r, isolate, led_lvl, link_r};
                `PIL_REG_IRQ_STAT: rdata <= {13'h0000, irq_stat_r};
                `PIL_REG_IRQ_MASK: rdata <= {13'h0000, irq_mask_r};
                `PIL_REG_STRAP:    rdata <= {11'h000, strap_r};
                default:           rdata <= 16'h0000;
            endcase
        end else begin
            rdata <= 16'h0000;
        end
    end

    // Events: link up on the last qualifying count, link down on detect loss
    assign ev[`PIL_EV_LINK_UP] = ~link_r & sd_s & (qual_cnt_r == QUAL_LAST);
    assign ev[`PIL_EV_LINK_DN] = link_r & ~sd_s;
    assign ev[`PIL_EV_ISO_CHG] = isolate ^ iso_q_r;

    // Level interrupt while any unmasked flag is set
    assign irq = |(irq_stat_r & irq_mask_r);

    // Signal detect qualification and immediate drop
    // Counter stops at its last value once link is up, so it cannot wrap
    // Any dropout of detect restarts the full qualification
    // The link-up event fires on the same edge that link rises
    always @(posedge mclk) begin
        if (!rst_n) begin
            qual_cnt_r <= {CNT_W{1'b0}};
            link_r     <= 1'b0;
        end else if (!sd_s) begin
            qual_cnt_r <= {CNT_W{1'b0}};
            link_r     <= 1'b0;
        end else if (!link_r) begin
            if (qual_cnt_r == QUAL_LAST)
                link_r <= 1'b1;
            else
                qual_cnt_r <= qual_cnt_r + 1'b1;
        end
    end

    // 10M link from link pulses within the gap window or received packets
    // Window is twice the pulse spacing so one missed pulse keeps link
    // Received packets refresh the window just as pulses do
    always @(posedge mclk) begin
        if (!rst_n) begin
            nlp_cnt_r <= {CNT_W{1'b0}};
            nlp_q_r   <= 1'b0;
            link10_r  <= 1'b0;
        end else begin
            nlp_q_r <= nlp_s;
            if ((nlp_s & ~nlp_q_r) | (rxc_rise & rxdv_s)) begin
                nlp_cnt_r <= {CNT_W{1'b0}};
                link10_r  <= 1'b1;
            end else if (nlp_cnt_r == NLP_LAST) begin
                link10_r <= 1'b0;
            end else begin
                nlp_cnt_r <= nlp_cnt_r + 1'b1;
            end
        end
    end

    // Activity stretch so short bursts are visible
    // Hold length is a choice; a raw flag would flicker too briefly to see
    always @(posedge mclk) begin
        if (!rst_n)
            act_cnt_r <= 16'h0000;
        else if (rx_act | tx_act | ierr_s)
            act_cnt_r <= `PIL_ACT_HOLD;
        else if (act_cnt_r != 16'h0000)
            act_cnt_r <= act_cnt_r - 16'h0001;
    end

    // Media side run state; halted while isolated
    // Only the MAC data path halts; registers and indicators keep running
    // Transmit copies are forced to zero so nothing reaches the media
    always @(posedge mclk) begin
        if (!rst_n) begin
            state_r    <= ST_IDLE;
            iso_q_r    <= 1'b0;
            media_en   <= 1'b0;
            core_txd   <= 4'h0;
            core_tx_en <= 1'b0;
            core_tx_er <= 1'b0;
        end else begin
            iso_q_r <= isolate;
            case (state_r)
                ST_IDLE: if (!isolate) state_r <= ST_RUN;
                ST_RUN:  if (isolate) state_r <= ST_IDLE;
                default: state_r <= ST_IDLE;
            endcase
            media_en   <= state_r & ~isolate;
            core_txd   <= isolate ? 4'h0 : mac_txd;
            core_tx_en <= ~isolate & mac_tx_en;
            core_tx_er <= ~isolate & mac_tx_er;
        end
    end

    // MAC-facing outputs, released while isolated
    // All eleven enables follow the isolate bit, the spare pad too
    assign mac_out      = {tx_clk_in, rx_clk_in, core_rx_dv, core_rx_er, core_rxd, core_col, core_crs, 1'b0};
    assign mac_out_oe_n = {11{isolate}};

    // Indicator levels before polarity
    // Each speed indicator needs qualified link and the matching speed
    // Activity and duplex do not depend on link
    assign led_lvl[0] = link_r & (spd_s == SPD_10M) & link10_r;
    assign led_lvl[1] = link_r & (spd_s == SPD_100M);
    assign led_lvl[2] = link_r & (spd_s == SPD_1G) & an_s & rxok_s;
    assign led_lvl[3] = act_cnt_r != 16'h0000;
    assign led_lvl[4] = fdx;
    // Pin drivers wait for the strap capture
    assign led_oe_n   = {5{~strap_done_r}};

    // Polarity per strap, one registered flop per indicator
    // A strap pulled high turns its indicator active low
    genvar gi;
    generate
        for (gi = 0; gi < NUM_LED; gi = gi + 1) begin : g_led
            always @(posedge mclk) begin
                if (!rst_n)
                    led_out[gi] <= 1'b0;
                else
                    led_out[gi] <= led_lvl[gi] ^ strap_r[gi];
            end
        end
    endgenerate
endmodule
`default_nettype wire

// *** tb/pil_monitor.sv ***
`timescale 1ns/1ps
`default_nettype none
module pil_monitor #(
    parameter QUAL_CYC = 50  // Detect qualify cycles
) (
    input wire logic        mclk,          // Clock
    input wire logic        rst_n,         // Reset
    input wire logic [3:0]  addr,          // Index
    input wire logic [15:0] wdata,         // Write data
    input wire logic        wr,            // Write
    input wire logic        rd,            // Read
    input wire logic [15:0] rdata,         // Read data
    input wire logic        core_tx_en,    // Media enable
    input wire logic [10:0] mac_out_oe_n,  // MAC enables
    input wire logic        media_en,      // Media active
    input wire logic        sig_det,       // Detect
    input wire logic        idle_err,      // Idle error
    input wire logic [4:0]  strap_in,      // Straps
    input wire logic [4:0]  led_out        // Indicators
);
    logic [31:0] sd_run_r;  // Cycles detect held
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    // Run length of signal detect
    always @(posedge mclk) begin
        if (!rst_n || !sig_det)
            sd_run_r <= 32'h0;
        else
            sd_run_r <= sd_run_r + 32'h1;
    end
    AST_OE_SET: assert property (wr && addr == 4'h0 && wdata[10] |=> mac_out_oe_n == 11'h7ff)
        else $error("isolate did not float");
    AST_OE_CLR: assert property (wr && addr == 4'h0 && !wdata[10] |=> mac_out_oe_n == 11'h000)
        else $error("outputs not restored");
    AST_TX_BLOCK: assert property (mac_out_oe_n[0] |=> !core_tx_en)
        else $error("transmit passed while isolated");
    AST_RD_CTRL: assert property (rd && addr == 4'h0 |=> rdata[10] == mac_out_oe_n[0])
        else $error("control read wrong");
    AST_MEDIA: assert property (mac_out_oe_n[0] |=> !media_en)
        else $error("media active while isolated");
    AST_QUAL: assert property ($rose(led_out[1] ^ strap_in[1]) |-> sd_run_r >= QUAL_CYC)
        else $error("link before qualify time");
    AST_DROP: assert property (!sig_det [*5] |-> led_out[2:0] == strap_in[2:0])
        else $error("link held without detect");
    AST_ACT: assert property ($rose(idle_err) |-> ##[1:6] led_out[3] != strap_in[3])
        else $error("activity not lit");
    AST_FDX: assert property (wr && addr == 4'h0 && wdata[8] |-> ##[1:4] led_out[4] != strap_in[4])
        else $error("duplex not lit");
endmodule
bind pil_isolate_leds pil_monitor #(.QUAL_CYC(QUAL_CYC)) i_mon (
    .mclk(mclk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .core_tx_en(core_tx_en), .mac_out_oe_n(mac_out_oe_n), .media_en(media_en),
    .sig_det(sig_det), .idle_err(idle_err), .strap_in(strap_in), .led_out(led_out)
);
`default_nettype wire

// *** tb/pil_mac_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module pil_mac_model (
    input  wire logic       clk,    // Clock
    input  wire logic       send,   // Frame request
    output logic [3:0]      txd,    // Nibble
    output logic            tx_en,  // Enable
    output logic            tx_er   // Error
);
    initial begin
        txd = 4'h0;
        tx_en = 1'b0;
        tx_er = 1'b0;
    end
    // Count nibbles in a frame, garble the bus between frames
    always @(posedge clk) begin
        tx_en <= send;
        tx_er <= send;  // Error flag marks whole frames so its gating shows
        txd <= send ? txd + 4'h1 : ~txd;
    end
endmodule
`default_nettype wire

// *** tb/tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    localparam QUAL = 50;                   // Shortened qualify time
    localparam logic [4:0] STRAP = 5'h11;   // Duplex and 10M active low
    logic mclk = 0, rst_n = 0, wr = 0, rd = 0, send = 0, tx_clk_in = 0, rx_clk_in = 0;
    logic sig_det = 0, nlp = 0, an_done = 0, rx_ok = 0, idle_err = 0, mac_tx_en, mac_tx_er, irq;
    logic core_tx_en, core_tx_er, media_en;
    logic [3:0] addr = 0, mac_txd, core_txd;
    logic [15:0] wdata = 0, rdata, v;
    logic [1:0] speed = 0;
    logic [10:0] mac_out, mac_out_oe_n;
    logic [4:0] led_oe_n, led_out, strap_in = STRAP;
    wire [3:0] core_rxd = mac_txd;          // Loop transmit back as receive
    wire core_rx_dv = mac_tx_en, core_rx_er = 1'b0, core_col = 1'b0, core_crs = 1'b0;
    int num_errors = 0, samples_checked = 0;
    logic [27:0] rows [4] = '{{16'h0400, 11'h7ff, 1'b0}, {16'h0000, 11'h000, 1'b1},
                              {16'h0500, 11'h7ff, 1'b0}, {16'h0100, 11'h000, 1'b1}};
    pil_isolate_leds #(.QUAL_CYC(QUAL), .NLP_CYC(128)) i_dut (
        .mclk(mclk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .irq(irq), .tx_clk_in(tx_clk_in), .rx_clk_in(rx_clk_in), .mac_txd(mac_txd),
        .mac_tx_en(mac_tx_en), .mac_tx_er(mac_tx_er), .core_txd(core_txd), .core_tx_en(core_tx_en),
        .core_tx_er(core_tx_er), .core_rxd(core_rxd), .core_rx_dv(core_rx_dv), .core_rx_er(core_rx_er),
        .core_col(core_col), .core_crs(core_crs), .mac_out(mac_out), .mac_out_oe_n(mac_out_oe_n),
        .media_en(media_en), .sig_det(sig_det), .nlp(nlp), .an_done(an_done), .rx_ok(rx_ok),
        .idle_err(idle_err), .speed(speed), .strap_in(strap_in), .led_oe_n(led_oe_n), .led_out(led_out)
    );
    pil_mac_model i_mac (.clk(mclk), .send(send), .txd(mac_txd), .tx_en(mac_tx_en), .tx_er(mac_tx_er));
    // Clocks and link pulses
    always #2 mclk = ~mclk;
    always #32 rx_clk_in = ~rx_clk_in;
    always #20 tx_clk_in = ~tx_clk_in;  // 25 MHz reference
    always begin
        repeat (32) @(posedge mclk);
        nlp <= ~nlp;
    end
    task automatic tally_and_finish;
        $display("errors %0d checks %0d", num_errors, samples_checked);
        if (num_errors == 0 && samples_checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
        @(posedge mclk);
        addr <= a;
        wdata <= d;
        wr <= 1;
        @(posedge mclk);
        wr <= 0;
    endtask
    task automatic rd_reg(input logic [3:0] a, input logic [15:0] e);
        @(posedge mclk);
        addr <= a;
        rd <= 1;
        @(posedge mclk);
        rd <= 0;
        #1 chk(rdata, e);
    endtask
    task automatic wait_led(input int b, input logic lit);
        int i;
        for (i = 0; i < 200 && (led_out[b] ^ STRAP[b]) !== lit; i++)
            @(posedge mclk) #1;
        chk(16'(led_out[b] ^ STRAP[b]), 16'(lit));
        if (i == 200)
            tally_and_finish();
    endtask
    // Main sequence
    initial begin
        repeat (3) @(posedge mclk);
        rst_n <= 1;
        repeat (4) @(posedge mclk) #1;
        chk({11'h0, led_out}, {11'h0, STRAP});
        chk({11'h0, led_oe_n}, 16'h0);
        wr_reg(4'h4, 16'hffff);
        rd_reg(4'h4, {11'h0, STRAP});
        rd_reg(4'hf, 16'h0);
        @(posedge mclk);
        idle_err <= 1;
        @(posedge mclk) idle_err <= 0;
        wait_led(3, 1);
        foreach (rows[r]) begin
            wr_reg(4'h0, rows[r][27:12]);
            repeat (4) @(posedge mclk) #1;
            chk({5'h0, mac_out_oe_n}, {5'h0, rows[r][11:1]});
            chk(16'(media_en), 16'(rows[r][0]));
            wait_led(4, rows[r][20]);
            @(posedge mclk) send <= 1;
            repeat (3) @(posedge mclk) #1;
            chk(16'(core_tx_en), 16'(rows[r][0]));
            chk(16'(core_tx_er), 16'(rows[r][0]));
            chk(16'(core_txd), rows[r][0] ? 16'(mac_txd - 4'h1) : 16'h0);
            chk({5'h0, mac_out}, {5'h0, tx_clk_in, rx_clk_in, mac_tx_en, 1'b0, mac_txd, 3'h0});
            @(posedge mclk) send <= 0;
            rd_reg(4'h0, rows[r][27:12]);
        end
        wr_reg(4'h2, 16'h0007);
        wr_reg(4'h3, 16'h0001);
        speed <= 1;
        sig_det <= 1;
        repeat (QUAL - 10) @(posedge mclk);
        sig_det <= 0;
        repeat (4) @(posedge mclk) #1;
        chk(16'(led_out[1]), 16'(STRAP[1]));
        @(posedge mclk);
        sig_det <= 1;
        an_done <= 1;
        rx_ok <= 1;
        wait_led(1, 1);
        chk(16'(irq), 16'h1);
        wr_reg(4'h3, 16'h0);
        #1 chk(16'(irq), 16'h0);
        wr_reg(4'h3, 16'h1);
        wr_reg(4'h2, 16'h1);
        #1 chk(16'(irq), 16'h0);
        for (int s = 0; s < 3; s++) begin
            @(posedge mclk) speed <= s[1:0];
            repeat (6) @(posedge mclk) #1;
            chk(16'(led_out[2:0]), 16'((3'h1 << s) ^ STRAP[2:0]));
        end
        @(posedge mclk) sig_det <= 0;
        repeat (5) @(posedge mclk) #1;
        chk(16'(led_out[2:0]), 16'(STRAP[2:0]));
        @(posedge mclk) rst_n <= 0;
        repeat (2) @(posedge mclk) #1;
        chk({4'h0, media_en, mac_out_oe_n}, 16'h0000);
        chk({11'h0, led_oe_n}, 16'h001f);
        @(posedge mclk) rst_n <= 1;
        repeat (4) @(posedge mclk) #1;
        chk({11'h0, led_out}, {11'h0, STRAP});
        rd_reg(4'h0, 16'h0);
        tally_and_finish();
    end
endmodule
`default_nettype wire
